// file: verilog/tdc_top.sv
// password-protected down counter of travel direction changes
// assumes pins are asynchronous and the encoder port runs on clk
//
// What this block does
// - each travel direction reversal lowers the count by one from the start value
// - a new password of zero switches the counting off; the direction pulse keeps running
// - passwords above 9999 are refused; zero means no password
// - start values above 16.67 million are refused
// - while activated and locked the coded display shows 56366
// - configuration writes need the assigned password entered first
// - replace output closes at about one year left, holds until counter reset
// - every direction change starts or restarts the monostable pulse for external counting
// - exhausted count locks travel and reports error code 950
// - only a power cycle (reset) releases the exhaustion lock
// - each accepted start value raises the reset tally by one
// - count saved to encoder every 100, then 1000, then 3000 changes
// - password then restore on loads the encoder count into the live count

module tdc_top import tdc_pkg::*; #(
  parameter int unsigned PULSE_CYC = PULSE_CYC_DEF
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // register bus
  input wire tdc_axi_req_s axiReq,
  output tdc_axi_rsp_s axiRsp,
  // drive pins
  input wire logic travelDirIn,
  input wire logic travelReqIn,
  output logic travelGrant,
  output logic driveLocked,
  output logic replaceNeeded,
  output logic directionPulseOutput,
  output logic irq,
  // absolute encoder
  output tdc_enc_out_s encOut,
  input wire tdc_enc_in_s encIn
);

  // ****************************************
  // pin synchronisers
  // ****************************************
  logic [1:0] pinRaw, pinSync;

  assign pinRaw = {travelReqIn, travelDirIn};

  for (genvar i = 0; i < 2; i++) begin : g_sync
    logic first_q, second_q;
    always_ff @(posedge clk) begin
      if (rst) begin
        first_q <= 1'b0;
        second_q <= 1'b0;
      end else begin
        first_q <= pinRaw[i];
        second_q <= first_q;
      end
    end
    assign pinSync[i] = second_q;
  end

  // ****************************************
  // bus front end
  // ****************************************
  logic wrEn, wrErr, rdErr;
  logic [31:0] wrAddr, wrData, rdAddr, rdData;
  logic [3:0] wrStrb;

  tdc_axil u_bus (
    .clk(clk),
    .rst(rst),
    .axiReq(axiReq),
    .axiRsp(axiRsp),
    .wrEn(wrEn),
    .wrAddr(wrAddr),
    .wrData(wrData),
    .wrStrb(wrStrb),
    .wrErr(wrErr),
    .rdAddr(rdAddr),
    .rdData(rdData),
    .rdErr(rdErr)
  );

  // ****************************************
  // state
  // ****************************************
  logic [23:0] cnt_q, cnt_d, startVal_q, startVal_d, warn_q, warn_d;
  logic [23:0] done_q, done_d, saveData_q, saveData_d;
  logic [15:0] tally_q, tally_d, pw_q, pw_d;
  logic [11:0] since_q, since_d, interval;
  logic [3:0] istat_q, istat_d, imask_q, imask_d, events, clrMask;
  logic unlocked_q, unlocked_d, lock_q, lock_d, replace_q, replace_d;
  logic saveV_q, saveV_d, dirPrev_q, primed_q, grant_q, grant_d;
  tdc_rs_e rs_q, rs_d;

  // ****************************************
  // decode of writes
  // ****************************************
  logic pwSet, okProt, wrFull, active, dirChange, dirStep, saveDue;
  logic startLoad, restStart, restDone, consume;
  logic [15:0] coded;

  assign pwSet = pw_q != 16'h0000;
  assign okProt = !pwSet || unlocked_q;
  assign wrFull = wrStrb == STRB_ALL;
  assign active = pwSet && startVal_q != 24'h000000;
  assign dirChange = primed_q && (pinSync[0] != dirPrev_q);
  assign dirStep = dirChange && active && cnt_q != 24'h000000 && !lock_q;
  assign restDone = rs_q == RS_WAIT && encIn.loadValid;

  always_comb begin
    startLoad = 1'b0;
    restStart = 1'b0;
    consume = 1'b0;
    clrMask = 4'h0;
    wrErr = 1'b0;
    pw_d = pw_q;
    warn_d = warn_q;
    imask_d = imask_q;
    unlocked_d = unlocked_q;
    unique case (wrAddr)
      A_START: begin
        if (okProt && wrFull && wrData[31:24] == 8'h00 && wrData[23:0] <= START_MAX) begin
          startLoad = wrEn;
          consume = wrEn;
        end else begin
          wrErr = 1'b1;
        end
      end
      A_PWENT: begin
        if (wrEn && pwSet && wrData == {16'h0000, pw_q}) begin
          unlocked_d = 1'b1;
        end
      end
      A_NEWPW: begin
        if (okProt && wrFull && wrData[31:16] == 16'h0000 && wrData[15:0] <= PW_MAX) begin
          pw_d = wrEn ? wrData[15:0] : pw_q;
          consume = wrEn;
        end else begin
          wrErr = 1'b1;
        end
      end
      A_RESTORE: begin
        if (okProt && wrFull) begin
          restStart = wrEn && wrData[0] && rs_q == RS_IDLE;
          consume = wrEn;
        end else begin
          wrErr = 1'b1;
        end
      end
      A_WARN: begin
        if (okProt && wrFull && wrData[31:24] == 8'h00) begin
          warn_d = wrEn ? wrData[23:0] : warn_q;
          consume = wrEn;
        end else begin
          wrErr = 1'b1;
        end
      end
      A_ISTAT: begin
        clrMask = wrEn ? wrData[3:0] : 4'h0;
      end
      A_IMASK: begin
        imask_d = wrEn ? wrData[3:0] : imask_q;
      end
      default: begin
        wrErr = 1'b1;
      end
    endcase
    // each accepted change spends the entry, so the next one needs it again
    if (consume) begin
      unlocked_d = 1'b0;
    end
  end

  // ****************************************
  // counter, lock, save and restore
  // ****************************************
  always_comb begin
    if (done_q < SAVE_EDGE1) begin
      interval = SAVE_STEP1;
    end else if (done_q < SAVE_EDGE2) begin
      interval = SAVE_STEP2;
    end else begin
      interval = SAVE_STEP3;
    end
  end

  assign saveDue = dirStep && (since_q + 12'h001 == interval);

  always_comb begin
    cnt_d = cnt_q;
    startVal_d = startVal_q;
    tally_d = tally_q;
    done_d = done_q;
    since_d = since_q;
    replace_d = replace_q;
    rs_d = rs_q;
    if (startLoad) begin
      cnt_d = wrData[23:0];
      startVal_d = wrData[23:0];
      tally_d = tally_q + 16'h0001;
      done_d = 24'h000000;
      since_d = 12'h000;
      replace_d = 1'b0;
    end else if (restDone) begin
      cnt_d = encIn.loadData;
    end else if (dirStep) begin
      cnt_d = cnt_q - 24'h000001;
      done_d = done_q + 24'h000001;
      since_d = saveDue ? 12'h000 : since_q + 12'h001;
    end
    if (!startLoad && active && cnt_q <= warn_q) begin
      replace_d = 1'b1;
    end
    unique case (rs_q)
      RS_IDLE: begin
        if (restStart) begin
          rs_d = RS_WAIT;
        end
      end
      RS_WAIT: begin
        if (encIn.loadValid) begin
          rs_d = RS_IDLE;
        end
      end
    endcase
  end

  assign lock_d = lock_q || (dirStep && cnt_q == 24'h000001);
  assign grant_d = pinSync[1] && !lock_d;
  // a new save overwrites a pending one, so the encoder always gets the latest count
  assign saveV_d = saveDue || (saveV_q && !encIn.saveReady);
  assign saveData_d = saveDue ? cnt_q - 24'h000001 : saveData_q;

  // ****************************************
  // interrupts
  // ****************************************
  always_comb begin
    events = 4'h0;
    events[IRQ_EXH] = lock_d && !lock_q;
    events[IRQ_REPL] = replace_d && !replace_q;
    events[IRQ_SAVE] = saveV_q && encIn.saveReady;
    events[IRQ_REST] = restDone;
    // a new event wins over a clear in the same cycle
    istat_d = (istat_q & ~clrMask) | events;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_q <= 24'h000000;
      startVal_q <= 24'h000000;
      warn_q <= WARN_RST;
      done_q <= 24'h000000;
      since_q <= 12'h000;
      saveData_q <= 24'h000000;
      tally_q <= 16'h0000;
      pw_q <= 16'h0000;
      istat_q <= 4'h0;
      imask_q <= 4'h0;
      unlocked_q <= 1'b0;
      lock_q <= 1'b0;
      replace_q <= 1'b0;
      saveV_q <= 1'b0;
      dirPrev_q <= 1'b0;
      primed_q <= 1'b0;
      grant_q <= 1'b0;
      rs_q <= RS_IDLE;
    end else begin
      cnt_q <= cnt_d;
      startVal_q <= startVal_d;
      warn_q <= warn_d;
      done_q <= done_d;
      since_q <= since_d;
      saveData_q <= saveData_d;
      tally_q <= tally_d;
      pw_q <= pw_d;
      istat_q <= istat_d;
      imask_q <= imask_d;
      unlocked_q <= unlocked_d;
      lock_q <= lock_d;
      replace_q <= replace_d;
      saveV_q <= saveV_d;
      dirPrev_q <= pinSync[0];
      primed_q <= 1'b1;
      grant_q <= grant_d;
      rs_q <= rs_d;
    end
  end

  // ****************************************
  // reads and outputs
  // ****************************************
  // coded display
  assign coded = (pwSet && !unlocked_q) ? CODED_LOCKED : CODED_OPEN;

  always_comb begin
    rdData = 32'h00000000;
    rdErr = 1'b0;
    unique case (rdAddr)
      A_START: rdData = {8'h00, startVal_q};
      A_PWENT: rdData = 32'h00000000;
      // the password itself is never readable
      A_NEWPW: rdData = 32'h00000000;
      A_CODED: rdData = {16'h0000, coded};
      A_COUNT: rdData = {8'h00, cnt_q};
      A_TALLY: rdData = {16'h0000, tally_q};
      A_RESTORE: rdData = {31'h00000000, rs_q == RS_WAIT};
      A_STATUS: begin
        rdData[ST_LOCK] = lock_q;
        rdData[ST_ACTIVE] = active;
        rdData[ST_UNLOCK] = unlocked_q;
        rdData[ST_REPL] = replace_q;
        rdData[ST_PWSET] = pwSet;
      end
      A_ISTAT: rdData = {28'h0000000, istat_q};
      A_IMASK: rdData = {28'h0000000, imask_q};
      A_WARN: rdData = {8'h00, warn_q};
      A_ERROR: rdData = lock_q ? {16'h0000, ERR_CODE} : 32'h00000000;
      default: rdErr = 1'b1;
    endcase
  end

  tdc_pulse #(.LEN(PULSE_CYC)) u_pulse (
    .clk(clk),
    .rst(rst),
    .trig(dirChange),
    .pulse(directionPulseOutput)
  );

  assign travelGrant = grant_q;
  assign driveLocked = lock_q;
  assign replaceNeeded = replace_q;
  assign irq = (istat_q & imask_q) != 4'h0;
  assign encOut = '{saveValid: saveV_q, saveData: saveData_q, loadReq: rs_q == RS_WAIT};

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_lastStep;
    dirStep && cnt_q == 24'h000001;
  endsequence

  sequence s_restLoad;
    (rs_q == RS_WAIT) ##0 (encIn.loadValid && !startLoad);
  endsequence

  property p_step;
    dirStep && !startLoad && !restDone |=> cnt_q == $past(cnt_q) - 1;
  endproperty
  a_step: assert property (p_step) else $error("count did not step down");

  property p_disable;
    pw_q == 16'h0000 |-> !active && !dirStep;
  endproperty
  a_disable: assert property (p_disable) else $error("counter active without password");

  property p_pwRange;
    pw_q <= PW_MAX && startVal_q <= START_MAX;
  endproperty
  a_pwRange: assert property (p_pwRange) else $error("password or start out of range");

  property p_coded;
    axiReq.arvalid && axiRsp.arready && axiReq.araddr == A_CODED && pwSet && !unlocked_q
      |=> axiRsp.rdata == {16'h0000, CODED_LOCKED};
  endproperty
  a_coded: assert property (p_coded) else $error("coded display wrong while locked");

  property p_guard;
    wrEn && wrAddr == A_START && pwSet && !unlocked_q |=> $stable(startVal_q) && $stable(tally_q);
  endproperty
  a_guard: assert property (p_guard) else $error("start changed without password");

  property p_replace;
    replace_q && !startLoad |=> replace_q;
  endproperty
  a_replace: assert property (p_replace) else $error("replace output dropped early");

  property p_pulse;
    dirChange |=> directionPulseOutput;
  endproperty
  a_pulse: assert property (p_pulse) else $error("no pulse after direction change");

  property p_exhaust;
    s_lastStep |=> lock_q && driveLocked ##1 lock_q ##1 !travelGrant;
  endproperty
  a_exhaust: assert property (p_exhaust) else $error("exhaustion did not lock");

  property p_tally;
    startLoad |=> tally_q == $past(tally_q) + 1 && cnt_q == $past(wrData[23:0]);
  endproperty
  a_tally: assert property (p_tally) else $error("tally not raised on start load");

  property p_save;
    saveDue |=> encOut.saveValid && encOut.saveData == $past(cnt_q) - 1 && since_q == 12'h000;
  endproperty
  a_save: assert property (p_save) else $error("save not issued at interval");

  property p_restore;
    s_restLoad |=> cnt_q == $past(encIn.loadData) && rs_q == RS_IDLE;
  endproperty
  a_restore: assert property (p_restore) else $error("restore did not load count");

  property p_locked;
    lock_q |-> !dirStep ##1 !travelGrant;
  endproperty
  a_locked: assert property (p_locked) else $error("travel granted while locked");

endmodule

// file: verilog/tdc_pkg.sv
// constants, carriers and state types of the travel direction down counter
// assumes a single 20 MHz clock and a synchronous active-high reset

package tdc_pkg;

  // ****************************************
  // clock and timing
  // ****************************************
  localparam int CLK_HZ = 20000000;
  localparam int PULSE_MS = 100;
  localparam int PULSE_CYC_DEF = CLK_HZ / 1000 * PULSE_MS;

  // ****************************************
  // register byte addresses
  // ****************************************
  localparam logic [31:0] A_START = 32'h00000000;
  localparam logic [31:0] A_PWENT = 32'h00000004;
  localparam logic [31:0] A_NEWPW = 32'h00000008;
  localparam logic [31:0] A_CODED = 32'h0000000c;
  localparam logic [31:0] A_COUNT = 32'h00000010;
  localparam logic [31:0] A_TALLY = 32'h00000014;
  localparam logic [31:0] A_RESTORE = 32'h00000018;
  localparam logic [31:0] A_STATUS = 32'h0000001c;
  localparam logic [31:0] A_ISTAT = 32'h00000020;
  localparam logic [31:0] A_IMASK = 32'h00000024;
  localparam logic [31:0] A_WARN = 32'h00000028;
  localparam logic [31:0] A_ERROR = 32'h0000002c;

  // ****************************************
  // limits, display codes, reset values
  // ****************************************
  localparam logic [23:0] START_MAX = 24'hfe5d30;
  localparam logic [15:0] PW_MAX = 16'h270f;
  localparam logic [15:0] CODED_LOCKED = 16'hdc2e;
  localparam logic [15:0] CODED_OPEN = 16'h54b9;
  localparam logic [15:0] ERR_CODE = 16'h03b6;
  localparam logic [23:0] WARN_RST = 24'h0030d4;
  localparam logic [3:0] STRB_ALL = 4'hf;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ****************************************
  // save schedule
  // ****************************************
  localparam logic [23:0] SAVE_EDGE1 = 24'h0003e8;
  localparam logic [23:0] SAVE_EDGE2 = 24'h002710;
  localparam logic [11:0] SAVE_STEP1 = 12'h064;
  localparam logic [11:0] SAVE_STEP2 = 12'h3e8;
  localparam logic [11:0] SAVE_STEP3 = 12'hbb8;

  // ****************************************
  // field positions
  // ****************************************
  localparam int ST_LOCK = 0;
  localparam int ST_ACTIVE = 1;
  localparam int ST_UNLOCK = 2;
  localparam int ST_REPL = 3;
  localparam int ST_PWSET = 4;
  localparam int IRQ_EXH = 0;
  localparam int IRQ_REPL = 1;
  localparam int IRQ_SAVE = 2;
  localparam int IRQ_REST = 3;

  // ****************************************
  // carriers and states
  // ****************************************
  typedef struct packed {
    logic awvalid;
    logic [31:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [31:0] araddr;
    logic rready;
  } tdc_axi_req_s;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } tdc_axi_rsp_s;

  typedef struct packed {
    logic saveValid;
    logic [23:0] saveData;
    logic loadReq;
  } tdc_enc_out_s;

  typedef struct packed {
    logic saveReady;
    logic loadValid;
    logic [23:0] loadData;
  } tdc_enc_in_s;

  typedef enum logic {RS_IDLE, RS_WAIT} tdc_rs_e;

endpackage

// file: verilog/tdc_pulse.sv
// monostable stretcher for the direction pulse output
// assumes trig is a one-cycle pulse on clk

module tdc_pulse import tdc_pkg::*; #(
  parameter int unsigned LEN = 2
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // trigger and pulse
  input wire logic trig,
  output logic pulse
);

  localparam int W = $clog2(LEN + 1);

  logic [W-1:0] cnt_q, cnt_d;
  logic pulse_q, pulse_d;

  // a change during a running pulse restarts it, so fast reversals merge
  always_comb begin
    cnt_d = cnt_q;
    if (trig) begin
      cnt_d = W'(LEN);
    end else if (cnt_q != '0) begin
      cnt_d = cnt_q - W'(1);
    end
    pulse_d = cnt_d != '0;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_q <= '0;
      pulse_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      pulse_q <= pulse_d;
    end
  end

  assign pulse = pulse_q;

endmodule

// file: verilog/tdc_axil.sv
// axi4-lite slave front end: one write and one read at a time
// assumes the owner answers wrErr, rdData and rdErr combinationally

module tdc_axil import tdc_pkg::*; (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // bus
  input wire tdc_axi_req_s axiReq,
  output tdc_axi_rsp_s axiRsp,
  // register side write
  output logic wrEn,
  output logic [31:0] wrAddr,
  output logic [31:0] wrData,
  output logic [3:0] wrStrb,
  input wire logic wrErr,
  // register side read
  output logic [31:0] rdAddr,
  input wire logic [31:0] rdData,
  input wire logic rdErr
);

  logic awHeld_q, awHeld_d, wHeld_q, wHeld_d;
  logic [31:0] wAddr_q, wAddr_d, wData_q, wData_d;
  logic [3:0] wStrb_q, wStrb_d;
  logic bValid_q, bValid_d, rValid_q, rValid_d;
  logic [1:0] bResp_q, bResp_d, rResp_q, rResp_d;
  logic [31:0] rData_q, rData_d;
  logic awTake, wTake, arTake;

  always_comb begin
    awTake = axiReq.awvalid && !awHeld_q;
    wTake = axiReq.wvalid && !wHeld_q;
    arTake = axiReq.arvalid && !rValid_q;
    wrEn = awHeld_q && wHeld_q && !bValid_q;
    awHeld_d = (awHeld_q && !wrEn) || awTake;
    wHeld_d = (wHeld_q && !wrEn) || wTake;
    wAddr_d = awTake ? axiReq.awaddr : wAddr_q;
    wData_d = wTake ? axiReq.wdata : wData_q;
    wStrb_d = wTake ? axiReq.wstrb : wStrb_q;
    bValid_d = wrEn || (bValid_q && !axiReq.bready);
    bResp_d = wrEn ? (wrErr ? RESP_SLVERR : RESP_OKAY) : bResp_q;
    rValid_d = arTake || (rValid_q && !axiReq.rready);
    rData_d = arTake ? (rdErr ? 32'h00000000 : rdData) : rData_q;
    rResp_d = arTake ? (rdErr ? RESP_SLVERR : RESP_OKAY) : rResp_q;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      awHeld_q <= 1'b0;
      wHeld_q <= 1'b0;
      wAddr_q <= 32'h00000000;
      wData_q <= 32'h00000000;
      wStrb_q <= 4'h0;
      bValid_q <= 1'b0;
      bResp_q <= RESP_OKAY;
      rValid_q <= 1'b0;
      rResp_q <= RESP_OKAY;
      rData_q <= 32'h00000000;
    end else begin
      awHeld_q <= awHeld_d;
      wHeld_q <= wHeld_d;
      wAddr_q <= wAddr_d;
      wData_q <= wData_d;
      wStrb_q <= wStrb_d;
      bValid_q <= bValid_d;
      bResp_q <= bResp_d;
      rValid_q <= rValid_d;
      rResp_q <= rResp_d;
      rData_q <= rData_d;
    end
  end

  assign wrAddr = wAddr_q;
  assign wrData = wData_q;
  assign wrStrb = wStrb_q;
  assign rdAddr = axiReq.araddr;
  assign axiRsp = '{awready: !awHeld_q, wready: !wHeld_q, bvalid: bValid_q, bresp: bResp_q,
                    arready: !rValid_q, rvalid: rValid_q, rdata: rData_q, rresp: rResp_q};

endmodule

// file: tb/tdc_enc_model.sv
// stand-in for the absolute encoder behind the save and restore port
// assumes the block clock; the stored count survives a block reset like a real encoder
module tdc_enc_model import tdc_pkg::*; #(
  parameter logic [23:0] INIT = 24'h5a5a5a
) (
  // clock
  input wire logic clk,
  // encoder port
  input wire tdc_enc_out_s encOut,
  output tdc_enc_in_s encIn,
  output logic [23:0] stored
);
  timeunit 1ns;
  timeprecision 1ns;
  // ****************************************
  // random-latency responder
  // ****************************************
  int seed = 32'h3f8d;
  int dly = 0;
  initial begin
    encIn = '0;
    stored = INIT;
  end
  // save and restore
  // idle load data is inverted so a stale read cannot pass
  always @(posedge clk) begin
    encIn.saveReady <= 1'b0;
    encIn.loadValid <= 1'b0;
    encIn.loadData <= ~stored;
    if (encOut.saveValid && encIn.saveReady) stored <= encOut.saveData;
    if ((encOut.saveValid && !encIn.saveReady) || (encOut.loadReq && !encIn.loadValid)) begin
      if (dly == 0) begin
        dly <= $unsigned($random(seed)) % 4;
        encIn.saveReady <= encOut.saveValid;
        encIn.loadValid <= encOut.loadReq && !encOut.saveValid;
        encIn.loadData <= stored;
      end else dly <= dly - 1;
    end
  end
endmodule

// file: tb/tdc_top_tb_top.sv
// self-checking bench of the travel direction down counter
// assumes a 20 MHz clock and a short pulse parameter to keep the run brief
module tdc_top_tb_top import tdc_pkg::*; ();
  timeunit 1ns;
  timeprecision 1ns;
  // ****************************************
  // harness
  // ****************************************
  localparam int PL = 8;
  logic clk = 0, rst = 1, dir = 0, treq = 0, grant, lockd, repl, dpulse, irq;
  tdc_axi_req_s req = '0;
  tdc_axi_rsp_s rsp;
  tdc_enc_out_s eo;
  tdc_enc_in_s ei;
  logic [23:0] stored;
  logic [31:0] rd;
  logic [1:0] rr;
  logic [15:0] pw;
  int error_cnt = 0, num_checks = 0, seed = 32'h3f8d;
  always #25 clk = ~clk;
  tdc_top #(.PULSE_CYC(PL)) u_tdc_top(.clk(clk), .rst(rst), .axiReq(req), .axiRsp(rsp), .travelDirIn(dir),
    .travelReqIn(treq), .travelGrant(grant), .driveLocked(lockd), .replaceNeeded(repl),
    .directionPulseOutput(dpulse), .irq(irq), .encOut(eo), .encIn(ei));
  tdc_enc_model u_tdc_enc_model(.clk(clk), .encOut(eo), .encIn(ei), .stored(stored));
  // ****************************************
  // tasks
  // ****************************************
  task automatic results();
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] s, e);
    num_checks++;
    if (s !== e) begin
      error_cnt++;
      $display("BAD %0t seen %h want %h", $time, s, e);
    end
  endtask
  // handshakes are sampled half a cycle before the edge that takes them
  task automatic bus(input logic w, input logic [31:0] a, d);
    int n;
    logic ta, tw, tb;
    @(posedge clk);
    if (w) begin
      req.awvalid <= 1; req.awaddr <= a; req.wvalid <= 1; req.wdata <= d; req.wstrb <= STRB_ALL; req.bready <= 1;
    end else begin
      req.arvalid <= 1; req.araddr <= a; req.rready <= 1;
    end
    tb = 0;
    for (n = 0; n < 40 && !tb; n++) begin
      @(negedge clk);
      ta = w ? req.awvalid && rsp.awready : req.arvalid && rsp.arready;
      tw = req.wvalid && rsp.wready;
      tb = w ? rsp.bvalid : rsp.rvalid;
      rd = rsp.rdata;
      rr = w ? rsp.bresp : rsp.rresp;
      @(posedge clk);
      if (ta) begin req.awvalid <= 0; req.arvalid <= 0; end
      if (tw) req.wvalid <= 0;
      if (tb) begin req.bready <= 0; req.rready <= 0; end
    end
    if (!tb) begin error_cnt++; results(); end
  endtask
  task automatic wr(input logic [31:0] a, d, input logic [1:0] e);
    bus(1, a, d);
    chk(rr, e);
  endtask
  task automatic rdc(input logic [31:0] a, e);
    bus(0, a, 0);
    chk(rd, e);
  endtask
  task automatic flip(input int k);
    int c;
    repeat (k) begin
      @(posedge clk);
      dir <= ~dir;
      c = 0;
      repeat (20) begin @(negedge clk); c += dpulse; end
      chk(c, PL);
    end
  endtask
  task automatic pwr();
    @(posedge clk); rst <= 1;
    repeat (5) @(posedge clk);
    rst <= 0;
    repeat (6) @(negedge clk);
  endtask
  // ****************************************
  // scenarios
  // ****************************************
  initial begin
    pwr();
    rdc(A_WARN, 32'h0030d4);
    rdc(A_CODED, 32'h54b9);
    bus(0, 32'h40, 0);
    chk(rr, RESP_SLVERR);
    pw = 16'(1 + $unsigned($random(seed)) % 9999);
    wr(A_NEWPW, pw, RESP_OKAY);
    rdc(A_CODED, 32'hdc2e);
    wr(A_START, 5, RESP_SLVERR);
    wr(A_PWENT, pw, RESP_OKAY);
    wr(A_NEWPW, 10000, RESP_SLVERR);
    wr(A_START, 32'hfe5d31, RESP_SLVERR);
    wr(A_START, 32'hfe5d30, RESP_OKAY);
    wr(A_PWENT, pw, RESP_OKAY);
    wr(A_START, 5, RESP_OKAY);
    rdc(A_TALLY, 2);
    wr(A_IMASK, 1, RESP_OKAY);
    treq <= 1;
    flip(4);
    rdc(A_COUNT, 1);
    chk(repl, 1);
    chk(grant, 1);
    flip(2);
    rdc(A_COUNT, 0);
    chk(lockd, 1);
    chk(grant, 0);
    rdc(A_ERROR, 32'h3b6);
    chk(repl, 1);
    chk(irq, 1);
    wr(A_ISTAT, 32'hf, RESP_OKAY);
    chk(irq, 0);
    $display("test lock done");
    pwr();
    chk(lockd, 0);
    chk(grant, 1);
    wr(A_NEWPW, pw, RESP_OKAY);
    wr(A_PWENT, pw, RESP_OKAY);
    wr(A_WARN, 150, RESP_OKAY);
    wr(A_PWENT, pw, RESP_OKAY);
    wr(A_START, 200, RESP_OKAY);
    chk(repl, 0);
    flip(99);
    chk(repl, 1);
    chk(stored, 24'h5a5a5a);
    flip(1);
    repeat (10) @(negedge clk);
    chk(stored, 100);
    rdc(A_ISTAT, 32'h6);
    rdc(A_TALLY, 1);
    $display("test save done");
    pwr();
    wr(A_NEWPW, pw, RESP_OKAY);
    wr(A_RESTORE, 1, RESP_SLVERR);
    wr(A_PWENT, pw, RESP_OKAY);
    wr(A_RESTORE, 1, RESP_OKAY);
    repeat (20) @(negedge clk);
    rdc(A_COUNT, 100);
    rdc(A_ISTAT, 32'h8);
    $display("test restore done");
    wr(A_PWENT, pw, RESP_OKAY);
    wr(A_START, 0, RESP_OKAY);
    wr(A_PWENT, pw, RESP_OKAY);
    wr(A_NEWPW, 0, RESP_OKAY);
    rdc(A_STATUS, 0);
    rdc(A_CODED, 32'h54b9);
    $display("test off done");
    results();
  end
endmodule
